// file: crt_timer.sv
// capture/reload timer with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "crt_params.svh"

module crt_timer #(
   parameter int ADDR_W   = `CRT_ADDR_W,
   parameter int TICK_DIV = `CRT_TICK_DIV
) (
   input  wire logic              aclk,            // device clock
   input  wire logic              aresetn,         // sync reset, low
   input  wire logic [ADDR_W-1:0] awaddr,          // write address
   input  wire logic              awvalid,         // write address valid
   output var  logic              awready,         // write address ready
   input  wire logic [31:0]       wdata,           // write data
   input  wire logic [3:0]        wstrb,           // write strobes
   input  wire logic              wvalid,          // write data valid
   output var  logic              wready,          // write data ready
   output var  logic [1:0]        bresp,           // write response
   output var  logic              bvalid,          // write response valid
   input  wire logic              bready,          // write response ready
   input  wire logic [ADDR_W-1:0] araddr,          // read address
   input  wire logic              arvalid,         // read address valid
   output var  logic              arready,         // read address ready
   output var  logic [31:0]       rdata,           // read data
   output var  logic [1:0]        rresp,           // read response
   output var  logic              rvalid,          // read data valid
   input  wire logic              rready,          // read data ready
   input  wire logic              count_input_pin, // external count
   input  wire logic              trigger_pin,     // capture/reload trigger
   input  wire logic              other_baud_ovf,  // other baud timer pulse
   input  wire logic              serial_var_mode, // serial mode 1 or 3
   output var  logic              rx_baud_tick,    // receive clock pulse
   output var  logic              tx_baud_tick,    // transmit clock pulse
   output var  logic              irq              // timer interrupt level
);

   // ---------------- registers ----------------
   logic [7:0]             ctrl_ff;
   logic [7:0]             mode_ff;
   crt_pkg::crt_word_t     cap_ff;
   crt_pkg::crt_word_t     cnt_ff;
   logic [1:0]             sts_ff;
   logic [1:0]             msk_ff;
   logic [$clog2(TICK_DIV)-1:0] pre_ff;
   logic [2:0]             cin_ff;
   logic [2:0]             trg_ff;

   // ---------------- bus and output state ----------------
   logic                   awready_ff;
   logic                   wready_ff;
   logic                   bvalid_ff;
   logic [1:0]             bresp_ff;
   logic                   arready_ff;
   logic                   rvalid_ff;
   logic [31:0]            rdata_ff;
   logic [1:0]             rresp_ff;
   logic [ADDR_W-3:0]      widx_ff;
   logic [7:0]             wdat_ff;
   logic                   wstb_ff;
   logic                   rx_tick_ff;
   logic                   tx_tick_ff;
   logic                   irq_ff;

   assign awready      = awready_ff;
   assign wready       = wready_ff;
   assign bvalid       = bvalid_ff;
   assign bresp        = bresp_ff;
   assign arready      = arready_ff;
   assign rvalid       = rvalid_ff;
   assign rdata        = rdata_ff;
   assign rresp        = rresp_ff;
   assign rx_baud_tick = rx_tick_ff;
   assign tx_baud_tick = tx_tick_ff;
   assign irq          = irq_ff;

   // ---------------- register write decode ----------------
   logic wr_en;
   logic [9:0] widx;
   logic wr_ctrl, wr_mode, wr_capl, wr_caph, wr_cntl, wr_cnth;
   logic wr_sts, wr_msk, wr_hit;

   assign wr_en   = !awready_ff && !wready_ff && !bvalid_ff;
   assign widx    = 10'(widx_ff);
   assign wr_ctrl = wr_en && wstb_ff && widx == `CRT_IDX_CTRL; // RULE15
   assign wr_mode = wr_en && wstb_ff && widx == `CRT_IDX_MODE;
   assign wr_capl = wr_en && wstb_ff && widx == `CRT_IDX_CAPL;
   assign wr_caph = wr_en && wstb_ff && widx == `CRT_IDX_CAPH;
   assign wr_cntl = wr_en && wstb_ff && widx == `CRT_IDX_CNTL;
   assign wr_cnth = wr_en && wstb_ff && widx == `CRT_IDX_CNTH;
   assign wr_sts  = wr_en && wstb_ff && widx == `CRT_IDX_IRQ_STS;
   assign wr_msk  = wr_en && wstb_ff && widx == `CRT_IDX_IRQ_MSK;
   assign wr_hit  = widx inside {`CRT_IDX_CTRL, `CRT_IDX_MODE,
                                 `CRT_IDX_CAPL, `CRT_IDX_CAPH,
                                 `CRT_IDX_CNTL, `CRT_IDX_CNTH,
                                 `CRT_IDX_IRQ_STS, `CRT_IDX_IRQ_MSK};

   // ---------------- write channel ----------------
   // address and data taken in either order; one write in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= crt_pkg::CRT_RESP_OKAY;
         widx_ff    <= '0;
         wdat_ff    <= 8'h00;
         wstb_ff    <= 1'b0;
      end else begin
         if (awready_ff && awvalid) begin
            awready_ff <= 1'b0;
            widx_ff    <= awaddr[ADDR_W-1:2];
         end
         if (wready_ff && wvalid) begin
            wready_ff <= 1'b0;
            wdat_ff   <= wdata[7:0];
            wstb_ff   <= wstrb[0];
         end
         if (wr_en) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? crt_pkg::CRT_RESP_OKAY
                                : crt_pkg::CRT_RESP_SLVERR;
         end
         if (bvalid_ff && bready) begin
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
         end
      end
   end

   // ---------------- read channel ----------------
   logic [9:0] ridx;
   logic [7:0] rd_byte;
   logic       rd_hit;

   assign ridx = 10'(araddr[ADDR_W-1:2]);

   always_comb begin
      rd_hit  = 1'b1;
      rd_byte = 8'h00;
      unique case (ridx)
         `CRT_IDX_CTRL:    rd_byte = ctrl_ff;
         `CRT_IDX_MODE:    rd_byte = mode_ff;
         `CRT_IDX_CAPL:    rd_byte = cap_ff[7:0];  // RULE14
         `CRT_IDX_CAPH:    rd_byte = cap_ff[15:8]; // RULE14
         `CRT_IDX_CNTL:    rd_byte = cnt_ff[7:0];
         `CRT_IDX_CNTH:    rd_byte = cnt_ff[15:8];
         `CRT_IDX_IRQ_STS: rd_byte = {6'h00, sts_ff};
         `CRT_IDX_IRQ_MSK: rd_byte = {6'h00, msk_ff};
         default:          rd_hit  = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= crt_pkg::CRT_RESP_OKAY;
      end else if (arready_ff && arvalid) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rdata_ff   <= {24'h00_0000, rd_byte};
         rresp_ff   <= rd_hit ? crt_pkg::CRT_RESP_OKAY
                              : crt_pkg::CRT_RESP_SLVERR;
      end else if (rvalid_ff && rready) begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   // ---------------- pin synchronisers ----------------
   // stage 0 feeds stage 1 only; stage 2 is the edge history
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cin_ff <= 3'h0;
         trg_ff <= 3'h0;
      end else begin
         cin_ff <= {cin_ff[1:0], count_input_pin}; // RULE16 RULE18
         trg_ff <= {trg_ff[1:0], trigger_pin};     // RULE16 RULE18
      end
   end

   logic cin_fall, trg_fall, trg_lvl;
   assign cin_fall = cin_ff[2] && !cin_ff[1]; // RULE18
   assign trg_fall = trg_ff[2] && !trg_ff[1]; // RULE18
   assign trg_lvl  = trg_ff[1];

   // ---------------- machine-cycle prescaler ----------------
   logic tick_int;
   assign tick_int = pre_ff == ($clog2(TICK_DIV))'(TICK_DIV - 1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_ff <= '0;
      end else if (tick_int) begin
         pre_ff <= '0;
      end else begin
         pre_ff <= pre_ff + 1'b1; // RULE17
      end
   end

   // ---------------- counting decisions ----------------
   logic run, baud, updn, up, cnt_en, ovf_up, unf, roll;
   logic trig_evt, cap_evt, rld_evt, rld_on_ovf, cnt_wr;

   assign run  = ctrl_ff[`CRT_CTRL_RUN];
   assign baud = ctrl_ff[`CRT_CTRL_RXSEL] || ctrl_ff[`CRT_CTRL_TXSEL];
   // direction comes from the trigger pin level in up/down mode
   assign updn = mode_ff[`CRT_MODE_UPDN] && !baud;
   assign up   = !updn || trg_lvl;
   assign cnt_en = run && (ctrl_ff[`CRT_CTRL_CT] ? cin_fall // RULE9 RULE10
                                                 : tick_int); // RULE17
   assign ovf_up = cnt_en && up && cnt_ff == `CRT_CNT_MAX;
   assign unf    = cnt_en && !up && cnt_ff == cap_ff;
   assign roll   = ovf_up || unf;
   // trigger pin is the direction input in up/down mode, not an event
   assign trig_evt = ctrl_ff[`CRT_CTRL_EXEN] && !baud && !updn
                     && trg_fall; // RULE8
   assign cap_evt  = trig_evt && ctrl_ff[`CRT_CTRL_CPRL]; // RULE11
   assign rld_evt  = trig_evt && !ctrl_ff[`CRT_CTRL_CPRL]; // RULE12
   assign rld_on_ovf = baud || updn
                       || !ctrl_ff[`CRT_CTRL_CPRL]; // RULE12 RULE13
   assign cnt_wr   = wr_cntl || wr_cnth;

   // ---------------- count ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= 16'h0000;
      end else if (cnt_wr) begin
         if (wr_cntl) begin
            cnt_ff[7:0] <= wdat_ff;
         end
         if (wr_cnth) begin
            cnt_ff[15:8] <= wdat_ff;
         end
      end else if (rld_evt || (ovf_up && rld_on_ovf)) begin
         cnt_ff <= cap_ff; // RULE12 RULE13 RULE14
      end else if (unf) begin
         cnt_ff <= `CRT_CNT_MAX;
      end else if (cnt_en) begin
         cnt_ff <= up ? cnt_ff + 1'b1 : cnt_ff - 1'b1; // RULE9 RULE10
      end
   end

   // ---------------- capture/reload value ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_ff <= 16'h0000;
      end else if (cap_evt) begin
         cap_ff <= cnt_ff; // RULE11 RULE14
      end else begin
         if (wr_capl) begin
            cap_ff[7:0] <= wdat_ff;
         end
         if (wr_caph) begin
            cap_ff[15:8] <= wdat_ff;
         end
      end
   end

   // ---------------- control and mode ----------------
   logic ovf_set;
   assign ovf_set = roll && !baud; // RULE1 RULE2

   // hardware set beats a software clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= `CRT_CTRL_RST; // RULE15
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= wdat_ff;
         end
         if (ovf_set) begin
            ctrl_ff[`CRT_CTRL_OVF] <= 1'b1; // RULE1
         end
         if (trig_evt) begin
            ctrl_ff[`CRT_CTRL_EXT] <= 1'b1; // RULE3
         end else if (roll && updn) begin
            ctrl_ff[`CRT_CTRL_EXT] <= !ctrl_ff[`CRT_CTRL_EXT];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_ff <= `CRT_MODE_RST;
      end else if (wr_mode) begin
         mode_ff <= wdat_ff;
      end
   end

   // ---------------- interrupt ----------------
   logic [1:0] sts_set;
   assign sts_set[`CRT_STS_OVF] = ovf_set;
   // up/down toggles of the trigger flag never reach here
   assign sts_set[`CRT_STS_EXT] = trig_evt; // RULE4 RULE5

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sts_ff <= 2'h0;
         msk_ff <= 2'h0;
         irq_ff <= 1'b0;
      end else begin
         sts_ff <= sts_set | (sts_ff & ~(wr_sts ? wdat_ff[1:0] : 2'h0));
         if (wr_msk) begin
            msk_ff <= wdat_ff[1:0];
         end
         irq_ff <= |(sts_ff & msk_ff); // RULE4
      end
   end

   // ---------------- serial baud clocks ----------------
   logic own_baud;
   assign own_baud = ovf_up && baud;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_tick_ff <= 1'b0;
         tx_tick_ff <= 1'b0;
      end else begin
         rx_tick_ff <= serial_var_mode && (ctrl_ff[`CRT_CTRL_RXSEL]
                       ? own_baud : other_baud_ovf); // RULE6
         tx_tick_ff <= serial_var_mode && (ctrl_ff[`CRT_CTRL_TXSEL]
                       ? own_baud : other_baud_ovf); // RULE7
      end
   end

   // ---------------- assertions ----------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_ovf_reload;
      ovf_up && rld_on_ovf && !cnt_wr && !rld_evt;
   endsequence

   sequence s_capture;
      cap_evt ##0 !wr_capl;
   endsequence

   a_ovf_flag_set: assert property ( // RULE1
      ovf_set |=> ctrl_ff[`CRT_CTRL_OVF] && sts_ff[`CRT_STS_OVF])
      else $error("overflow did not set flag");

   a_ovf_baud_quiet: assert property ( // RULE2
      $rose(ctrl_ff[`CRT_CTRL_OVF]) |->
         $past(!baud) || $past(wr_ctrl && wdat_ff[`CRT_CTRL_OVF]))
      else $error("overflow flag set while clocking serial port");

   a_ext_flag_set: assert property ( // RULE3
      trig_evt |=> ctrl_ff[`CRT_CTRL_EXT])
      else $error("trigger event did not set flag");

   a_ext_irq: assert property ( // RULE4
      trig_evt && msk_ff[`CRT_STS_EXT] && !wr_msk |-> ##2 irq_ff)
      else $error("trigger flag gave no interrupt");

   a_updn_no_irq: assert property ( // RULE5
      updn |=> !$rose(sts_ff[`CRT_STS_EXT]))
      else $error("up/down mode raised trigger interrupt");

   a_rx_clock_src: assert property ( // RULE6
      serial_var_mode && ctrl_ff[`CRT_CTRL_RXSEL] && own_baud
         |=> rx_tick_ff)
      else $error("receive clock missed timer overflow");

   a_tx_clock_src: assert property ( // RULE7
      serial_var_mode && !ctrl_ff[`CRT_CTRL_TXSEL] && !other_baud_ovf
         |=> !tx_tick_ff)
      else $error("transmit clock not from other timer");

   a_trig_ignored: assert property ( // RULE8
      trg_fall && (!ctrl_ff[`CRT_CTRL_EXEN] || baud) && !wr_capl
         && !wr_caph |=> $stable(cap_ff))
      else $error("disabled trigger changed capture value");

   a_stopped_hold: assert property ( // RULE9
      !run && !cnt_wr && !rld_evt |=> $stable(cnt_ff))
      else $error("count moved while stopped");

   a_capture_copy: assert property ( // RULE11
      s_capture |=> cap_ff == $past(cnt_ff))
      else $error("capture did not copy count");

   a_ovf_reload: assert property ( // RULE12
      s_ovf_reload |=> cnt_ff == $past(cap_ff))
      else $error("overflow did not reload count");

   a_tick_period: assert property ( // RULE17
      tick_int |=> !tick_int ##(TICK_DIV - 1) tick_int)
      else $error("machine tick period wrong");

   a_write_answer: assert property (
      wr_en |=> bvalid_ff)
      else $error("write not answered");

endmodule

`default_nettype wire

// file: crt_params.svh
// offsets, fields, reset values and counts of the capture/reload timer
// Contract
// RULE1 - rollover sets overflow flag; software clears it
// RULE2 - no overflow flag while either serial clock selected
// RULE3 - trigger capture or reload sets trigger flag
// RULE4 - set trigger flag raises timer interrupt
// RULE5 - up/down mode: trigger flag raises no interrupt
// RULE6 - receive clock: this overflow or other timer
// RULE7 - transmit clock: this overflow or other timer
// RULE8 - trigger enabled acts unless clocking serial port; the code also ignores it as an event in up/down mode
// RULE9 - count only while run control is set
// RULE10 - select internal ticks or external count pin edges
// RULE11 - capture mode: trigger edge copies count out
// RULE12 - reload mode: reload on overflow and trigger
// RULE13 - serial clocking forces auto-reload on overflow
// RULE14 - high and low registers form 16-bit value
// RULE15 - control register index C8, resets to zero
// RULE16 - count pin and trigger pin are port inputs
// RULE17 - timer ticks once every twelve clocks
// RULE18 - pins synchronised; falling edge is high then low
`ifndef CRT_PARAMS_SVH
`define CRT_PARAMS_SVH

// register indices; byte address is four times the index
`define CRT_IDX_CTRL    10'h0C8
`define CRT_IDX_MODE    10'h0C9
`define CRT_IDX_CAPL    10'h0CA
`define CRT_IDX_CAPH    10'h0CB
`define CRT_IDX_CNTL    10'h0CC
`define CRT_IDX_CNTH    10'h0CD
`define CRT_IDX_IRQ_STS 10'h0D0
`define CRT_IDX_IRQ_MSK 10'h0D1

// control register fields
`define CRT_CTRL_OVF    7
`define CRT_CTRL_EXT    6
`define CRT_CTRL_RXSEL  5
`define CRT_CTRL_TXSEL  4
`define CRT_CTRL_EXEN   3
`define CRT_CTRL_RUN    2
`define CRT_CTRL_CT     1
`define CRT_CTRL_CPRL   0
`define CRT_CTRL_RST    8'h00

// mode register fields
`define CRT_MODE_UPDN   0
`define CRT_MODE_CLKOUT 1
`define CRT_MODE_RST    8'h00

// interrupt status and mask fields
`define CRT_STS_OVF     0
`define CRT_STS_EXT     1

`define CRT_CNT_MAX     16'hFFFF
`define CRT_TICK_DIV    12
`define CRT_ADDR_W      12

`endif

// file: crt_pkg.sv
// shared types of the capture/reload timer
package crt_pkg;
   typedef logic [15:0] crt_word_t;
   typedef logic [7:0]  crt_byte_t;
   typedef enum logic [1:0] {
      CRT_RESP_OKAY   = 2'b00,
      CRT_RESP_SLVERR = 2'b10
   } crt_resp_e;
endpackage

// file: crt_pins.sv
// far-side model: count pin, trigger pin and the other baud timer
`timescale 1ns/1ps
`default_nettype none

module crt_pins (
   input  wire logic aclk,            // device clock
   output var  logic count_input_pin, // external count
   output var  logic trigger_pin,     // capture/reload trigger
   output var  logic other_baud_ovf   // other baud timer pulse
);
   // port pins idle high through their pull-ups
   initial begin
      count_input_pin = 1'b1;
      trigger_pin     = 1'b1;
      other_baud_ovf  = 1'b0;
   end

   // levels held several clocks so the synchroniser sees both
   task automatic fall_count(input int n);
      for (int i = 0; i < n; i++) begin
         repeat (4) @(posedge aclk);
         count_input_pin <= 1'b0;
         repeat (4) @(posedge aclk);
         count_input_pin <= 1'b1;
      end
   endtask

   task automatic fall_trigger();
      repeat (4) @(posedge aclk);
      trigger_pin <= 1'b0;
      repeat (4) @(posedge aclk);
      trigger_pin <= 1'b1;
   endtask

   task automatic baud_pulse();
      @(posedge aclk);
      other_baud_ovf <= 1'b1;
      @(posedge aclk);
      other_baud_ovf <= 1'b0;
   endtask
endmodule

`default_nettype wire

// file: capture_reload_timer_bench.sv
// self-checking bench for the capture/reload timer
`timescale 1ns/1ps
`default_nettype none
`include "crt_params.svh"

module capture_reload_timer_bench;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  wstrb = 4'hF;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic        count_input_pin, trigger_pin, other_baud_ovf;
   logic        serial_var_mode = 1'b0;
   logic        rx_baud_tick, tx_baud_tick, irq;
   int          bad_count = 0, total_checks = 0, rx_n = 0, tx_n = 0;
   logic [7:0]  v, v2;
   logic [1:0]  r;
   typedef struct {
      logic [9:0] idx;
      logic [7:0] wd, rd;
      logic [1:0] rs;
   } crt_row_s;
   crt_row_s rows[7] = '{
      '{`CRT_IDX_MODE, 8'h02, 8'h02, 2'b00},
      '{`CRT_IDX_CAPL, 8'h5A, 8'h5A, 2'b00},
      '{`CRT_IDX_CAPH, 8'hA5, 8'hA5, 2'b00},
      '{`CRT_IDX_CNTL, 8'h3C, 8'h3C, 2'b00},
      '{`CRT_IDX_CNTH, 8'hC3, 8'hC3, 2'b00},
      '{`CRT_IDX_IRQ_MSK, 8'h03, 8'h03, 2'b00},
      '{10'h0C0, 8'h55, 8'h00, 2'b10}};

   always #5 aclk = ~aclk;

   crt_timer #(.TICK_DIV(2)) dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .count_input_pin(count_input_pin), .trigger_pin(trigger_pin),
      .other_baud_ovf(other_baud_ovf), .serial_var_mode(serial_var_mode),
      .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick), .irq(irq));

   crt_pins pins (
      .aclk(aclk), .count_input_pin(count_input_pin),
      .trigger_pin(trigger_pin), .other_baud_ovf(other_baud_ovf));

   always @(posedge aclk) begin
      if (rx_baud_tick === 1'b1) rx_n++;
      if (tx_baud_tick === 1'b1) tx_n++;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      bit a_done, w_done;
      a_done = 0;
      w_done = 0;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(a_done && w_done)) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) begin
            a_done = 1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            w_done = 1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [9:0] idx, output logic [7:0] d);
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      d = rdata[7:0];
      r = rresp;
      chk(rdata[31:8], 24'h0);
      rready <= 1'b0;
   endtask

   task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      rd(idx, d);
      chk(d, exp);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #200us;
      bad_count++;
      conclude();
   end

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) rdchk(rows[i].idx, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i].idx, rows[i].wd);
         chk(r, rows[i].rs);
         rd(rows[i].idx, v);
         chk({r, v}, {rows[i].rs, rows[i].rd});
      end
      // overflow with auto-reload from FFF0
      wr(`CRT_IDX_MODE, 8'h00);
      wr(`CRT_IDX_CAPL, 8'hF0);
      wr(`CRT_IDX_CAPH, 8'hFF);
      wr(`CRT_IDX_CNTL, 8'hFE);
      wr(`CRT_IDX_CNTH, 8'hFF);
      wr(`CRT_IDX_IRQ_MSK, 8'h01);
      wr(`CRT_IDX_CTRL, 8'h04);
      for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge aclk);
      chk(irq, 1'b1);
      // flag seen before software touches the control register
      rdchk(`CRT_IDX_CTRL, 8'h84);
      wr(`CRT_IDX_CTRL, 8'h80);
      rdchk(`CRT_IDX_CNTH, 8'hFF);
      wr(`CRT_IDX_IRQ_STS, 8'h01);
      rdchk(`CRT_IDX_IRQ_STS, 8'h00);
      chk(irq, 1'b0);
      rdchk(`CRT_IDX_CTRL, 8'h80);
      rd(`CRT_IDX_CNTL, v);
      repeat (20) @(posedge aclk);
      rd(`CRT_IDX_CNTL, v2);
      chk(v2, v);
      // capture with the counter held still
      wr(`CRT_IDX_CNTL, 8'h34);
      wr(`CRT_IDX_CNTH, 8'h12);
      wr(`CRT_IDX_IRQ_MSK, 8'h03);
      wr(`CRT_IDX_CTRL, 8'h09);
      pins.fall_trigger();
      repeat (6) @(posedge aclk);
      rdchk(`CRT_IDX_CAPL, 8'h34);
      rdchk(`CRT_IDX_CAPH, 8'h12);
      rdchk(`CRT_IDX_CTRL, 8'h49);
      chk(irq, 1'b1);
      wr(`CRT_IDX_IRQ_STS, 8'h03);
      wr(`CRT_IDX_CTRL, 8'h01);
      // trigger ignored with the enable off
      wr(`CRT_IDX_CNTL, 8'h78);
      pins.fall_trigger();
      repeat (6) @(posedge aclk);
      rdchk(`CRT_IDX_CAPL, 8'h34);
      rdchk(`CRT_IDX_CTRL, 8'h01);
      // serial clocking: forced reload, no overflow flag
      serial_var_mode <= 1'b1;
      wr(`CRT_IDX_CAPL, 8'hF0);
      wr(`CRT_IDX_CAPH, 8'hFF);
      // start near the top so several rollovers fit in the window
      wr(`CRT_IDX_CNTL, 8'hF0);
      wr(`CRT_IDX_CNTH, 8'hFF);
      rx_n = 0;
      tx_n = 0;
      wr(`CRT_IDX_CTRL, 8'h3D);
      pins.fall_trigger();
      repeat (100) @(posedge aclk);
      rdchk(`CRT_IDX_CTRL, 8'h3D);
      wr(`CRT_IDX_CTRL, 8'h00);
      chk(rx_n > 0, 1'b1);
      chk(tx_n > 0, 1'b1);
      rdchk(`CRT_IDX_CNTH, 8'hFF);
      rdchk(`CRT_IDX_CTRL, 8'h00);
      rdchk(`CRT_IDX_CAPL, 8'hF0);
      rx_n = 0;
      tx_n = 0;
      pins.baud_pulse();
      pins.baud_pulse();
      repeat (3) @(posedge aclk);
      chk(rx_n, 2);
      chk(tx_n, 2);
      serial_var_mode <= 1'b0;
      // up/down rolls toggle the trigger flag without interrupt
      wr(`CRT_IDX_IRQ_STS, 8'h03);
      wr(`CRT_IDX_IRQ_MSK, 8'h02);
      wr(`CRT_IDX_MODE, 8'h01);
      wr(`CRT_IDX_CTRL, 8'h04);
      repeat (60) @(posedge aclk);
      wr(`CRT_IDX_CTRL, 8'h00);
      rd(`CRT_IDX_IRQ_STS, v);
      chk(v[1], 1'b0);
      chk(irq, 1'b0);
      // external event counting
      wr(`CRT_IDX_MODE, 8'h00);
      wr(`CRT_IDX_CNTL, 8'h00);
      wr(`CRT_IDX_CNTH, 8'h00);
      wr(`CRT_IDX_CTRL, 8'h06);
      pins.fall_count(3);
      repeat (6) @(posedge aclk);
      wr(`CRT_IDX_CTRL, 8'h00);
      rdchk(`CRT_IDX_CNTL, 8'h03);
      // trigger edge reloads in reload mode, timer stopped
      wr(`CRT_IDX_CTRL, 8'h08);
      pins.fall_trigger();
      repeat (6) @(posedge aclk);
      rdchk(`CRT_IDX_CNTL, 8'hF0);
      rdchk(`CRT_IDX_CTRL, 8'h48);
      chk(irq, 1'b1);
      // second reset mid-run
      wr(`CRT_IDX_CTRL, 8'h04);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rdchk(`CRT_IDX_CTRL, 8'h00);
      rdchk(`CRT_IDX_CNTH, 8'h00);
      conclude();
   end
endmodule

`default_nettype wire
